// >>> rtl/rtcml_top.v
/*
  Room temperature decision logic: P/PI actuating value, two-point
  outputs with hysteresis, dead zone placement and mode selection.
  Assumes all inputs come from logic on core_clk_in; temp_valid_in
  marks a new temperature sample; temperatures in 0.01 K, signed.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rtcml_consts.vh"
module rtcml_top (
  input wire core_clk_in, // 250 MHz controller clock
  input wire resetn_in, // asynchronous reset, active low
  input wire temp_valid_in, // new temperature sample pulse
  input wire signed [15:0] temp_in, // actual temperature
  input wire signed [15:0] heat_sp_in, // heating setpoint
  input wire [15:0] band_in, // proportional bandwidth, nonzero
  input wire [15:0] int_step_in, // integral gain per sample, 8 frac bits
  input wire [15:0] dead_zone_in, // configured dead zone width
  input wire [15:0] heat_hyst_in, // heating hysteresis magnitude
  input wire [15:0] cool_hyst_in, // cooling hysteresis magnitude
  input wire heat_two_point_in, // heating uses two-point control
  input wire cool_two_point_in, // cooling uses two-point control
  input wire heat_hyst_pos_in, // heating hysteresis positive
  input wire pi_mode_in, // 1 = PI, 0 = P
  input wire preset_valid_in, // preset mode received pulse
  input wire [1:0] preset_in, // preset mode value
  input wire manual_valid_in, // manual mode selection pulse
  input wire [1:0] manual_in, // manual mode value
  input wire scene_valid_in, // scene byte received pulse
  input wire [7:0] scene_in, // scene byte
  input wire presence_set_in, // presence detected pulse
  input wire presence_clr_in, // presence cleared pulse
  input wire presence_button_in, // presence-button option
  input wire window_open_in, // window contact level, 1 = open
  input wire [31:0] comfort_ext_in, // comfort extension in cycles
  output reg [7:0] heat_act_out, // heating actuating value, percent
  output reg [7:0] cool_act_out, // cooling actuating value, percent
  output reg heat_on_out, // two-point heating output
  output reg cool_on_out, // two-point cooling output
  output reg signed [15:0] cool_sp_out, // placed cooling setpoint
  output reg [1:0] mode_out, // current operating mode
  output reg presence_out // presence flag
);
  reg [1:0] preset_reg;
  reg [1:0] pre_presence_reg;
  reg ext_timer_run_reg;
  reg [31:0] ext_cnt_reg;
  reg [23:0] heat_int_reg;
  reg [23:0] cool_int_reg;
  reg scene_recall_reg;
  wire [1:0] scene_mode;
  wire scene_store;
  wire signed [17:0] zone_ext;
  wire signed [17:0] cool_sp_wide;
  wire signed [16:0] heat_dev;
  wire signed [16:0] cool_dev;
  wire [7:0] heat_p;
  wire [7:0] cool_p;
  wire [1:0] cur_mode;
  wire [8:0] heat_sum;
  wire [8:0] cool_sum;
  wire [7:0] heat_pi;
  wire [7:0] cool_pi;

  assign scene_store = scene_valid_in && scene_in[`RTCML_SCENE_SAVE_BIT];

  rtcml_scene_mem u_scene (
    .core_clk_in(core_clk_in),
    .wr_en_in(scene_store),
    .addr_in(scene_in[5:0]),
    .wr_data_in(cur_mode),
    .rd_data_out(scene_mode)
  );

  // The dead zone grows by each hysteresis that belongs to a two-point side.
  assign zone_ext = {2'b00, dead_zone_in}
    + (heat_two_point_in ? {2'b00, heat_hyst_in} : 18'sh00000)
    + (cool_two_point_in ? {2'b00, cool_hyst_in} : 18'sh00000);
  assign cool_sp_wide = {{2{heat_sp_in[15]}}, heat_sp_in} + zone_ext;

  assign heat_dev = {heat_sp_in[15], heat_sp_in} - {temp_in[15], temp_in};
  assign cool_dev = {temp_in[15], temp_in} - {cool_sp_out[15], cool_sp_out};

  function [7:0] p_value;
    input signed [16:0] dev;
    input [15:0] band;
    reg [23:0] scaled;
    reg [23:0] quot;
    begin
      scaled = 24'h000000;
      quot = 24'h000000;
      if (dev <= 17'sh00000)
      begin
        p_value = `RTCML_ACT_RESET;
      end
      else if ({1'b0, dev[15:0]} >= {1'b0, band})
      begin
        p_value = `RTCML_FULL_SCALE;
      end
      else
      begin
        scaled = {8'h00, dev[15:0]} * `RTCML_PCT_SCALE;
        quot = scaled / {8'h00, band};
        p_value = quot[7:0];
      end
    end
  endfunction

  assign heat_p = p_value(heat_dev, band_in);
  assign cool_p = p_value(cool_dev, band_in);

  // The stored integral share was capped against an older P value, so the
  // sum is clamped again before it reaches the output.
  assign heat_sum = {1'b0, heat_p}
    + {1'b0, heat_int_reg[`RTCML_INT_FRAC+7:`RTCML_INT_FRAC]};
  assign cool_sum = {1'b0, cool_p}
    + {1'b0, cool_int_reg[`RTCML_INT_FRAC+7:`RTCML_INT_FRAC]};
  assign heat_pi = (heat_sum > {1'b0, `RTCML_FULL_SCALE}) ? `RTCML_FULL_SCALE
    : heat_sum[7:0];
  assign cool_pi = (cool_sum > {1'b0, `RTCML_FULL_SCALE}) ? `RTCML_FULL_SCALE
    : cool_sum[7:0];

  // PI: the integral share accumulates per sample and sits on top of P.
  function [23:0] int_next;
    input [23:0] acc;
    input signed [16:0] dev;
    input [15:0] step;
    input [7:0] p;
    reg [24:0] sum;
    reg [23:0] cap;
    begin
      cap = {`RTCML_FULL_SCALE - p, 16'h0000} >> (16 - `RTCML_INT_FRAC);
      sum = {1'b0, acc} + {9'h000, step};
      if (dev == 17'sh00000)
      begin
        int_next = acc;
      end
      else if (dev < 17'sh00000)
      begin
        int_next = 24'h000000;
      end
      else if (sum[23:0] > cap || sum[24])
      begin
        int_next = cap;
      end
      else
      begin
        int_next = sum[23:0];
      end
    end
  endfunction

  // Two-point state from the previous state and the thresholds.
  function hyst_next;
    input state;
    input cooling;
    input pos;
    input signed [16:0] t;
    input signed [16:0] sp;
    input signed [16:0] h;
    begin
      hyst_next = state;
      if (cooling)
      begin
        if (!state && t > sp) hyst_next = 1'b1;
        if (state && t <= sp - h) hyst_next = 1'b0;
      end
      else if (pos)
      begin
        if (!state && t < sp) hyst_next = 1'b1;
        if (state && t >= sp + h) hyst_next = 1'b0;
      end
      else
      begin
        if (!state && t < sp - h) hyst_next = 1'b1;
        if (state && t >= sp) hyst_next = 1'b0;
      end
    end
  endfunction

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      heat_act_out <= `RTCML_ACT_RESET;
      cool_act_out <= `RTCML_ACT_RESET;
      heat_on_out <= 1'b0;
      cool_on_out <= 1'b0;
      heat_int_reg <= 24'h000000;
      cool_int_reg <= 24'h000000;
      cool_sp_out <= 16'sh0000;
    end
    else
    begin
      cool_sp_out <= cool_sp_wide[15:0];
      if (temp_valid_in)
      begin
        if (pi_mode_in)
        begin
          heat_int_reg <= int_next(heat_int_reg, heat_dev, int_step_in,
                                   heat_p);
          cool_int_reg <= int_next(cool_int_reg, cool_dev, int_step_in,
                                   cool_p);
        end
        else
        begin
          heat_int_reg <= 24'h000000;
          cool_int_reg <= 24'h000000;
        end
        // In P mode continuous outputs stay zero in the dead zone; in PI mode the old integral share shows on the first sample there, and on every sample at a setpoint.
        heat_act_out <= heat_two_point_in ? `RTCML_ACT_RESET
          : heat_pi;
        cool_act_out <= cool_two_point_in ? `RTCML_ACT_RESET
          : cool_pi;
        heat_on_out <= heat_two_point_in && hyst_next(heat_on_out, 1'b0,
          heat_hyst_pos_in, {temp_in[15], temp_in},
          {heat_sp_in[15], heat_sp_in}, {1'b0, heat_hyst_in});
        cool_on_out <= cool_two_point_in && hyst_next(cool_on_out, 1'b1,
          1'b0, {temp_in[15], temp_in},
          {cool_sp_out[15], cool_sp_out}, {1'b0, cool_hyst_in});
      end
    end
  end

  // Mode selection.
  assign cur_mode = window_open_in ? `RTCML_MODE_FROST
    : (presence_out ? `RTCML_MODE_COMFORT : preset_reg);

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scene_recall_reg <= 1'b0;
    end
    else
    begin
      scene_recall_reg <= scene_valid_in && !scene_in[`RTCML_SCENE_SAVE_BIT];
    end
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      preset_reg <= `RTCML_PRESET_RESET;
      pre_presence_reg <= `RTCML_PRESET_RESET;
      presence_out <= 1'b0;
      ext_timer_run_reg <= 1'b0;
      ext_cnt_reg <= 32'h00000000;
      mode_out <= `RTCML_PRESET_RESET;
    end
    else
    begin
      mode_out <= cur_mode;
      // Last request wins, except a preset equal to pre_presence_reg during presence; scene recall acts a cycle late and beats manual; manual beats preset.
      if (scene_recall_reg)
      begin
        preset_reg <= scene_mode;
      end
      else if (manual_valid_in)
      begin
        preset_reg <= manual_in;
      end
      else if (preset_valid_in)
      begin
        if (!(presence_out && preset_in == pre_presence_reg))
        begin
          preset_reg <= preset_in;
        end
      end
      if (presence_set_in && !presence_out)
      begin
        presence_out <= 1'b1;
        pre_presence_reg <= preset_reg;
        // Standby runs comfort without limit; night or frost is timed.
        ext_timer_run_reg <= (preset_reg == `RTCML_MODE_NIGHT) ||
          (preset_reg == `RTCML_MODE_FROST);
        ext_cnt_reg <= 32'h00000000;
      end
      else if (presence_out)
      begin
        if (presence_clr_in)
        begin
          presence_out <= 1'b0;
          ext_timer_run_reg <= 1'b0;
        end
        else if (presence_button_in && preset_valid_in &&
                 preset_in != pre_presence_reg)
        begin
          presence_out <= 1'b0;
          ext_timer_run_reg <= 1'b0;
        end
        else if (ext_timer_run_reg)
        begin
          if (ext_cnt_reg + 32'h00000001 >= comfort_ext_in)
          begin
            presence_out <= 1'b0;
            ext_timer_run_reg <= 1'b0;
          end
          else
          begin
            ext_cnt_reg <= ext_cnt_reg + 32'h00000001;
          end
        end
      end
    end
  end
endmodule // rtcml_top
`default_nettype wire

// >>> rtl/rtcml_consts.vh
/*
  Constants for the room temperature mode logic: mode codes, scale,
  widths and reset values.
  Assumes temperatures are signed fixed point in units of 0.01 K.
*/
`ifndef RTCML_CONSTS_VH
`define RTCML_CONSTS_VH
`define RTCML_MODE_COMFORT 2'h0
`define RTCML_MODE_STANDBY 2'h1
`define RTCML_MODE_NIGHT 2'h2
`define RTCML_MODE_FROST 2'h3
`define RTCML_FULL_SCALE 8'h64
`define RTCML_PCT_SCALE 24'h000064
`define RTCML_INT_FRAC 8
`define RTCML_PRESET_RESET 2'h0
`define RTCML_ACT_RESET 8'h00
`define RTCML_SCENE_SAVE_BIT 7
`define RTCML_SCENE_COUNT 64
`endif

// >>> rtl/rtcml_scene_mem.v
/*
  Scene store: 64 entries of one operating mode each.
  Assumes the surroundings keep it powered so it stands in for
  non-volatile storage; read data come out of a register.
*/
`timescale 1ns/10ps
`default_nettype none
module rtcml_scene_mem (
  input wire core_clk_in, // controller clock
  input wire wr_en_in, // write strobe
  input wire [5:0] addr_in, // scene index
  input wire [1:0] wr_data_in, // mode to store
  output reg [1:0] rd_data_out // registered mode of addressed scene
);
  reg [1:0] mem_reg [0:`RTCML_SCENE_COUNT-1];
  always @(posedge core_clk_in)
  begin
    if (wr_en_in)
    begin
      mem_reg[addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_reg[addr_in];
  end
endmodule // rtcml_scene_mem
`default_nettype wire

// >>> test/rtcml_top_properties.sv
/* Port checks for rtcml_top, bound below.
   Assumes all ports share core_clk_in. */
`timescale 1ns/10ps
`default_nettype none
`include "rtcml_consts.vh"
module rtcml_top_chk (
  input wire core_clk_in, // clock
  input wire resetn_in, // reset, active low
  input wire temp_valid_in, // sample
  input wire signed [15:0] temp_in, // actual
  input wire signed [15:0] heat_sp_in, // setpoint
  input wire [15:0] dead_zone_in, // dead zone
  input wire [15:0] heat_hyst_in, // heat hyst
  input wire [15:0] cool_hyst_in, // cool hyst
  input wire heat_two_point_in, // heat 2-pt
  input wire cool_two_point_in, // cool 2-pt
  input wire window_open_in, // window
  input wire [7:0] heat_act_out, // heat value
  input wire [7:0] cool_act_out, // cool value
  input wire heat_on_out, // heat state
  input wire cool_on_out, // cool state
  input wire signed [15:0] cool_sp_out, // cool sp
  input wire [1:0] mode_out // mode
);
  wire signed [17:0] tmp_w = temp_in;
  wire signed [17:0] hsp_w = heat_sp_in;
  wire signed [17:0] csp_w = cool_sp_out;
  wire signed [17:0] hh_w = {2'b00, heat_hyst_in};
  wire signed [17:0] ch_w = {2'b00, cool_hyst_in};
  wire [15:0] csp_exp_w = heat_sp_in + dead_zone_in +
    (heat_two_point_in ? heat_hyst_in : 16'h0000) +
    (cool_two_point_in ? cool_hyst_in : 16'h0000);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  AST_ACT_RANGE: assert property (
    heat_act_out <= 8'h64 && cool_act_out <= 8'h64)
    else $error("Actuating value above full scale.");
  AST_COOL_SP: assert property (
    $past(resetn_in) |-> cool_sp_out == $past(csp_exp_w))
    else $error("Cooling setpoint misplaced.");
  AST_WIN_FROST: assert property (
    window_open_in |=> mode_out == `RTCML_MODE_FROST)
    else $error("Open window did not force frost mode.");
  AST_HEAT_OFF: assert property (
    temp_valid_in && heat_two_point_in && tmp_w >= hsp_w + hh_w
    |=> !heat_on_out) else $error("Heating on above threshold.");
  AST_HEAT_ON: assert property (
    temp_valid_in && heat_two_point_in && tmp_w < hsp_w - hh_w
    |=> heat_on_out) else $error("Heating off below threshold.");
  AST_COOL_ON: assert property (
    temp_valid_in && cool_two_point_in && tmp_w > csp_w
    |=> cool_on_out) else $error("Cooling off above setpoint.");
  AST_COOL_OFF: assert property (
    temp_valid_in && cool_two_point_in && tmp_w + ch_w <= csp_w
    |=> !cool_on_out) else $error("Cooling on below threshold.");
  AST_DEAD_ZONE: assert property (
    !(heat_on_out && cool_on_out))
    else $error("Heating and cooling both on.");
  AST_HOLD: assert property (
    !temp_valid_in && $stable(heat_two_point_in) &&
    $stable(cool_two_point_in) |=>
    $stable(heat_on_out) && $stable(cool_on_out))
    else $error("Two-point state moved without a sample.");
endmodule // rtcml_top_chk
bind rtcml_top rtcml_top_chk i_chk (.*);
`default_nettype wire

// >>> test/rtcml_room_model.sv
/* Room sensor model: sends the room temperature every PER cycles.
   Assumes the block's clock; between samples the value toggles. */
`timescale 1ns/10ps
`default_nettype none
module rtcml_room_model #(parameter int PER = 6) (
  input wire logic core_clk_in, // clock
  input wire logic resetn_in, // reset, active low
  input wire logic signed [15:0] room_in, // room temperature
  output logic temp_valid_out, // sample pulse
  output logic signed [15:0] temp_out // sample value
);
  logic [7:0] cnt_reg;
  wire wrap = (cnt_reg == 8'(PER - 1));
  always_ff @(posedge core_clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      cnt_reg <= 8'h00;
      temp_valid_out <= 1'b0;
      temp_out <= 16'h0000;
    end
    else
    begin
      cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
      temp_valid_out <= wrap;
      // The value is only good with the pulse, so it is spoilt between.
      temp_out <= wrap ? room_in : ~temp_out;
    end
endmodule // rtcml_room_model
`default_nettype wire

// >>> test/test_rtcml_top.sv
/* Bench for rtcml_top: control cases from a table, then modes.
   Assumes rtcml_room_model feeds the samples. */
`timescale 1ns/10ps
`default_nettype none
module test_rtcml_top;
  typedef struct packed {
    logic [2:0] f;
    logic [15:0] t;
    logic [7:0] a;
    logic [1:0] o;
    logic [15:0] c;
  } rtcml_row_t;
  logic core_clk_in, resetn_in, temp_valid_in, heat_two_point_in;
  logic cool_two_point_in, heat_hyst_pos_in, pi_mode_in, preset_valid_in;
  logic manual_valid_in, scene_valid_in, presence_set_in, presence_clr_in;
  logic presence_button_in, window_open_in, heat_on_out, cool_on_out;
  logic presence_out;
  logic signed [15:0] temp_in, heat_sp_in, cool_sp_out, room;
  logic [15:0] band_in, int_step_in, dead_zone_in, heat_hyst_in, cool_hyst_in;
  logic [1:0] preset_in, manual_in, mode_out;
  logic [7:0] scene_in, heat_act_out, cool_act_out, a1;
  logic [31:0] comfort_ext_in;
  int num_errors = 0, tests_run = 0, cyc = 0;
  rtcml_row_t rows [17] = '{
    '{3'h0, 16'h05dc, 8'h64, 2'h0, 16'h0960},
    '{3'h0, 16'h076c, 8'h19, 2'h0, 16'h0960},
    '{3'h0, 16'h0834, 8'h00, 2'h0, 16'h0960},
    '{3'h2, 16'h076c, 8'h19, 2'h0, 16'h09c4},
    '{3'h4, 16'h073a, 8'h00, 2'h2, 16'h09c4},
    '{3'h4, 16'h079e, 8'h00, 2'h2, 16'h09c4},
    '{3'h4, 16'h07d0, 8'h00, 2'h0, 16'h09c4},
    '{3'h4, 16'h079e, 8'h00, 2'h0, 16'h09c4},
    '{3'h4, 16'h076b, 8'h00, 2'h2, 16'h09c4},
    '{3'h5, 16'h0802, 8'h00, 2'h2, 16'h09c4},
    '{3'h5, 16'h0834, 8'h00, 2'h0, 16'h09c4},
    '{3'h5, 16'h07cf, 8'h00, 2'h2, 16'h09c4},
    '{3'h6, 16'h0a8c, 8'h00, 2'h1, 16'h0a28},
    '{3'h6, 16'h09f6, 8'h00, 2'h1, 16'h0a28},
    '{3'h6, 16'h09c4, 8'h00, 2'h0, 16'h0a28},
    '{3'h6, 16'h08fc, 8'h00, 2'h0, 16'h0a28},
    '{3'h6, 16'h0a29, 8'h00, 2'h1, 16'h0a28}};
  rtcml_top i_dut (.*);
  rtcml_room_model i_room (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .room_in(room),
    .temp_valid_out(temp_valid_in), .temp_out(temp_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Two pulses are awaited so that the second surely carries the new value.
  task automatic smp(input logic [2:0] f, input logic [15:0] t);
    @(posedge core_clk_in);
    {heat_two_point_in, cool_two_point_in, heat_hyst_pos_in} <= f;
    room <= t;
    repeat (2)
    begin
      @(posedge core_clk_in);
      while (temp_valid_in !== 1'b1)
        @(posedge core_clk_in);
    end
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic req(input logic [4:0] v, input logic [7:0] d);
    @(posedge core_clk_in);
    {preset_valid_in, manual_valid_in, scene_valid_in} <= v[4:2];
    {presence_set_in, presence_clr_in} <= v[1:0];
    {preset_in, manual_in, scene_in} <= {d[1:0], d[1:0], d};
    @(posedge core_clk_in);
    {preset_valid_in, manual_valid_in, scene_valid_in} <= 3'h0;
    {presence_set_in, presence_clr_in} <= 2'h0;
    repeat (5) @(posedge core_clk_in);
    #1;
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    resetn_in = 1'b0;
    room = 16'h07d0;
    {heat_two_point_in, cool_two_point_in, heat_hyst_pos_in} = 3'h0;
    {pi_mode_in, presence_button_in, window_open_in} = 3'h0;
    {preset_valid_in, manual_valid_in, scene_valid_in} = 3'h0;
    {presence_set_in, presence_clr_in} = 2'h0;
    {preset_in, manual_in, scene_in} = 12'h000;
    {heat_sp_in, band_in, dead_zone_in} = 48'h07d0_0190_0190;
    {heat_hyst_in, cool_hyst_in, int_step_in} = 48'h0064_0064_0100;
    comfort_ext_in = 32'h0000000a;
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(16'({presence_out, mode_out, heat_act_out}), 16'h0000);
    foreach (rows[i])
    begin
      smp(rows[i].f, rows[i].t);
      chk(16'(heat_act_out), 16'(rows[i].a));
      chk(cool_sp_out, rows[i].c);
      if (rows[i].f[2])
        chk(16'(heat_on_out), 16'(rows[i].o[1]));
      if (rows[i].f[1])
        chk(16'(cool_on_out), 16'(rows[i].o[0]));
    end
    // Continuous cooling against the cooling setpoint of 24.00.
    smp(3'h0, 16'h0a28);
    chk(16'({heat_act_out, cool_act_out}), 16'h0032);
    smp(3'h0, 16'h0b54);
    chk(16'(cool_act_out), 16'h0064);
    smp(3'h0, 16'h0898);
    chk(16'({heat_act_out, cool_act_out}), 16'h0000);
    @(posedge core_clk_in);
    pi_mode_in <= 1'b1;
    smp(3'h0, 16'h076c);
    a1 = heat_act_out;
    chk(16'(heat_act_out >= 8'h19), 16'h0001);
    smp(3'h0, 16'h076c);
    chk(16'(heat_act_out > a1), 16'h0001);
    smp(3'h0, 16'h07d0);
    a1 = heat_act_out;
    smp(3'h0, 16'h07d0);
    chk(16'(heat_act_out), 16'(a1));
    req(5'h10, 8'h02);
    chk(16'(mode_out), 16'h0002);
    req(5'h08, 8'h01);
    chk(16'(mode_out), 16'h0001);
    req(5'h04, 8'h85);
    req(5'h10, 8'h03);
    req(5'h04, 8'h05);
    chk(16'(mode_out), 16'h0001);
    req(5'h02, 8'h00);
    repeat (20) @(posedge core_clk_in);
    chk(16'({presence_out, mode_out}), 16'h0004);
    @(posedge core_clk_in);
    presence_button_in <= 1'b1;
    req(5'h10, 8'h01);
    chk(16'({presence_out, mode_out}), 16'h0004);
    req(5'h10, 8'h02);
    chk(16'({presence_out, mode_out}), 16'h0002);
    req(5'h02, 8'h00);
    chk(16'({presence_out, mode_out}), 16'h0004);
    repeat (20) @(posedge core_clk_in);
    chk(16'({presence_out, mode_out}), 16'h0002);
    // Presence taken in standby is untimed, so only the clear pulse or, with the button option, a differing preset ends it.
    req(5'h10, 8'h01);
    req(5'h02, 8'h00);
    req(5'h01, 8'h00);
    chk(16'({presence_out, mode_out}), 16'h0001);
    @(posedge core_clk_in);
    window_open_in <= 1'b1;
    req(5'h10, 8'h00);
    chk(16'(mode_out), 16'h0003);
    @(posedge core_clk_in);
    window_open_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    chk(16'(mode_out), 16'h0000);
    conclude();
  end
endmodule // test_rtcml_top
`default_nettype wire
